// ### logic/fas_map.svh
// Offsets, sizes, codes and timing counts of the flash access sequencer.
`ifndef FAS_MAP_SVH
`define FAS_MAP_SVH
`define FAS_CMD_BASE        32'h007e_0000
`define FAS_CODE_USER_BYTES 23'h40_0000
`define FAS_BOOT_BYTES      23'h00_8000
`define FAS_DATA_BYTES      23'h01_0000
`define FAS_CODE_BLK_BYTES  23'h00_2000
`define FAS_TM_LO           22'h01_0000
`define FAS_TM_HI           22'h01_4000
`define FAS_CODE_PROG_BYTES 23'h00_0100
`define FAS_DATA_PROG_BYTES 23'h00_0004
`define FAS_DATA_ERASE_BYTES 23'h00_0040
`define FAS_CODE_PROG_WORDS 8'h40
`define FAS_DATA_PROG_WORDS 8'h01
`define FAS_OP_PROG         8'he8
`define FAS_OP_ERASE        8'h20
`define FAS_DATA_RD_TICKS   4'h8
`define FAS_FLASH_CLOCK_DIV        4'h2
`define FAS_PE_TICKS        8'h10
`define FAS_BGO_BANK_BIT    21
`define FAS_ERASED_CODE     8'hff
`endif

// ### logic/fas_pkg.sv
// Types shared by the flash access sequencer.
package fas_pkg;
   typedef enum logic [1:0] {
      FAS_ARR_NONE,
      FAS_ARR_WRITE,
      FAS_ARR_ERASE,
      FAS_ARR_COMMIT
   } fas_arr_op_t;
   typedef struct packed {
      logic [7:0]  opcode;
      logic        boot_area;
      logic        data_array;
      logic [21:0] offset;
   } fas_cmd_t;
   typedef struct packed {
      fas_arr_op_t op;
      logic        data_array;
      logic        boot_area;
      logic [21:0] addr;
      logic [22:0] len;
      logic [31:0] wdata;
      logic [7:0]  fill;
   } fas_arr_req_t;
   typedef enum {
      FAS_IDLE,
      FAS_LOAD,
      FAS_RUN
   } fas_state_t;
endpackage

// ### logic/fas_sequencer.sv
// Flash array access sequencer: reads, command window and program/erase.
//
// Behaviour
// R01: Code-array read data is returned one core-clock cycle after the request.
// R02: Data-array byte or word reads finish after eight flash-clock ticks.
// R03: Code erase fills with all ones; erased data-array contents are undefined.
// R04: Program and erase commands are writes decoded at the command window.
// R05: Code program is 256 bytes; user erase one block, boot 32 KB.
// R06: Data array programs in 4-byte units and erases in 64-byte units.
// R07: Code user area 4 MB, user-boot 32 KB, data area 64 KB.
// R08: With trusted region active, unauthorised reads of blocks 8 and 9 block.
// R09: Code reads continue while a data-array operation runs in background.
// R10: Code reads during code programming only from the other bank.
// R11: Interrupt requests are accepted while self-programming is running.
// R12: The off-board programmer path may not program the data array.
// R13: The other party enters program/erase mode per array before commands.
// R14: Separate sticky violation flags for code and data array accesses.
// R15: Command errors set a lock flag, with an enabled interrupt output.
// R16: Window writes without matching entry are ignored and flagged.
`timescale 1ns/1ps
`default_nettype none
`include "fas_map.svh"

module fas_sequencer
   import fas_pkg::*;
#(
   parameter logic [3:0] FLASH_CLOCK_DIV = `FAS_FLASH_CLOCK_DIV,
   parameter logic [7:0] PE_TICKS = `FAS_PE_TICKS
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         code_rd_req_in,
   input  wire logic [21:0]  code_rd_addr_in,
   input  wire logic [31:0]  code_array_rdata_in,
   output logic      [21:0]  code_array_addr_out,
   output logic              code_rd_valid_out,
   output logic      [31:0]  code_rd_data_out,
   input  wire logic         data_rd_req_in,
   input  wire logic         data_rd_byte_in,
   input  wire logic [15:0]  data_rd_addr_in,
   input  wire logic [31:0]  data_array_rdata_in,
   output logic      [15:0]  data_array_addr_out,
   output logic              data_rd_busy_out,
   output logic              data_rd_valid_out,
   output logic      [31:0]  data_rd_data_out,
   input  wire logic         cmd_wr_in,
   input  wire logic [31:0]  cmd_addr_in,
   input  wire logic [31:0]  cmd_data_in,
   input  wire logic         code_array_pe_entry_in,
   input  wire logic         data_array_pe_entry_in,
   input  wire logic         serial_programmer_in,
   input  wire logic         trusted_region_active_in,
   input  wire logic         trusted_region_auth_in,
   output fas_arr_req_t      arr_req_out,
   output logic              pe_busy_out,
   output logic              background_operation_out,
   output logic              code_array_violation_flag_out,
   output logic              data_array_violation_flag_out,
   output logic              command_lock_flag_out,
   input  wire logic         code_viol_clear_in,
   input  wire logic         data_viol_clear_in,
   input  wire logic         cmd_lock_clear_in,
   input  wire logic         command_lock_irq_enable_in,
   output logic              command_lock_irq_out,
   input  wire logic         irq_req_in,
   output logic              irq_accept_out
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.

   function automatic logic fas_aligned(input logic [21:0] off,
                                        input logic [22:0] unit);
      logic [22:0] mask;
      mask = unit - 23'h1;
      fas_aligned = (({1'b0, off} & mask) == 23'h0);
   endfunction

   function automatic logic fas_in_tm(input logic [21:0] addr);
      fas_in_tm = (addr >= `FAS_TM_LO) && (addr < `FAS_TM_HI);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Flash clock enable divider.

   logic [3:0] div_cnt;
   wire        flash_tick = (div_cnt == FLASH_CLOCK_DIV - 4'h1);

   always_ff @(posedge clk_in) begin
      if (reset_in || flash_tick) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command window decode.

   fas_state_t  state;
   fas_state_t  next_state;
   fas_cmd_t    op_cmd;
   logic [7:0]  words_left;
   logic [7:0]  pe_cnt;
   logic [21:0] wr_offset;
   logic        code_flag;
   logic        data_flag;
   logic        lock_flag;

   wire fas_cmd_t cmd = fas_cmd_t'(cmd_data_in);
   wire win_hit   = cmd_wr_in && (cmd_addr_in == `FAS_CMD_BASE); // R04
   wire is_prog   = (cmd.opcode == `FAS_OP_PROG);
   wire is_erase  = (cmd.opcode == `FAS_OP_ERASE);
   wire entry_ok  = cmd.data_array ? data_array_pe_entry_in
                                   : code_array_pe_entry_in; // R13 R16
   wire serial_no = cmd.data_array && serial_programmer_in; // R12
   wire data_rng  = ({1'b0, cmd.offset} < `FAS_DATA_BYTES); // R07
   wire boot_rng  = ({1'b0, cmd.offset} < `FAS_BOOT_BYTES); // R07
   wire code_rng  = cmd.boot_area ? boot_rng
                  : ({1'b0, cmd.offset} < `FAS_CODE_USER_BYTES); // R07
   wire range_ok  = cmd.data_array ? data_rng : code_rng;
   wire [22:0] prog_unit = cmd.data_array ? `FAS_DATA_PROG_BYTES
                                          : `FAS_CODE_PROG_BYTES; // R05 R06
   wire [22:0] erase_unit = cmd.data_array ? `FAS_DATA_ERASE_BYTES
                          : cmd.boot_area ? `FAS_BOOT_BYTES
                          : `FAS_CODE_BLK_BYTES; // R05 R06
   wire align_ok  = is_prog ? fas_aligned(cmd.offset, prog_unit)
                            : fas_aligned(cmd.offset, erase_unit);
   wire idle      = (state == FAS_IDLE);
   wire cmd_valid = (is_prog || is_erase) && range_ok && align_ok;
   wire start_ok  = idle && win_hit && !lock_flag && entry_ok
                    && !serial_no && cmd_valid;
   wire reject    = idle && win_hit && !start_ok; // R16
   wire lock_set  = win_hit && ((state == FAS_RUN)
                    || (idle && entry_ok && !lock_flag && !cmd_valid)); // R15
   wire load_hit  = (state == FAS_LOAD) && win_hit;
   wire last_word = load_hit && (words_left == 8'h1);
   wire pe_done   = (state == FAS_RUN) && flash_tick
                    && (pe_cnt == PE_TICKS - 8'h1);

   ////////////////////////////////////////////////////////////////////////
   // Program/erase sequencer.

   always_comb begin
      next_state = state;
      case (state)
         FAS_IDLE: begin
            if (start_ok) begin
               next_state = is_prog ? FAS_LOAD : FAS_RUN;
            end
         end
         FAS_LOAD: begin
            if (last_word) begin
               next_state = FAS_RUN;
            end
         end
         FAS_RUN: begin
            if (pe_done) begin
               next_state = FAS_IDLE;
            end
         end
         default: next_state = FAS_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= FAS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         op_cmd     <= '0;
         wr_offset  <= 22'h0;
         words_left <= 8'h0;
      end else if (start_ok) begin
         op_cmd     <= cmd;
         wr_offset  <= cmd.offset;
         words_left <= cmd.data_array ? `FAS_DATA_PROG_WORDS
                                      : `FAS_CODE_PROG_WORDS; // R05 R06
      end else if (load_hit) begin
         wr_offset  <= wr_offset + 22'h4;
         words_left <= words_left - 8'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in || state != FAS_RUN) begin
         pe_cnt <= 8'h0;
      end else if (flash_tick) begin
         pe_cnt <= pe_cnt + 8'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array request.

   fas_arr_req_t next_arr;

   always_comb begin
      next_arr = '0;
      if (start_ok && is_erase) begin
         next_arr.op         = FAS_ARR_ERASE;
         next_arr.data_array = cmd.data_array;
         next_arr.boot_area  = cmd.boot_area;
         next_arr.addr       = cmd.offset;
         next_arr.len        = erase_unit;
         next_arr.fill       = cmd.data_array ? 8'h00
                                              : `FAS_ERASED_CODE; // R03
      end else if (load_hit) begin
         next_arr.op         = last_word ? FAS_ARR_COMMIT : FAS_ARR_WRITE;
         next_arr.data_array = op_cmd.data_array;
         next_arr.boot_area  = op_cmd.boot_area;
         next_arr.addr       = wr_offset;
         next_arr.len        = op_cmd.data_array ? `FAS_DATA_PROG_BYTES
                                                 : `FAS_CODE_PROG_BYTES;
         next_arr.wdata      = cmd_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         arr_req_out <= '0;
      end else begin
         arr_req_out <= next_arr;
      end
   end

   assign pe_busy_out = !idle;
   assign background_operation_out = !idle && op_cmd.data_array; // R09

   ////////////////////////////////////////////////////////////////////////
   // Code-array read path.

   wire tm_block  = trusted_region_active_in && !trusted_region_auth_in
                    && fas_in_tm(code_rd_addr_in); // R08
   wire bgo_clash = !idle && !op_cmd.data_array && !op_cmd.boot_area
                    && (code_rd_addr_in[`FAS_BGO_BANK_BIT]
                        == op_cmd.offset[`FAS_BGO_BANK_BIT]); // R10
   wire code_bad  = code_rd_req_in && (tm_block || bgo_clash);

   assign code_array_addr_out = code_rd_addr_in;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         code_rd_valid_out <= 1'b0;
         code_rd_data_out  <= 32'h0;
      end else begin
         code_rd_valid_out <= code_rd_req_in; // R01 R09
         if (code_rd_req_in) begin
            code_rd_data_out <= code_bad ? 32'h0 : code_array_rdata_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data-array read path.

   logic [3:0]  rd_ticks;
   logic [15:0] rd_addr;
   logic        rd_byte;
   logic        rd_bad;
   wire         rd_start = data_rd_req_in && !data_rd_busy_out;
   wire         rd_last  = data_rd_busy_out && flash_tick
                           && (rd_ticks == `FAS_DATA_RD_TICKS - 4'h1); // R02
   wire         data_busy_pe = !idle && op_cmd.data_array;
   wire [4:0]   rd_shift = {rd_addr[1:0], 3'h0};
   wire [31:0]  rd_word  = data_array_rdata_in >> rd_shift;
   wire [31:0]  rd_value = rd_byte ? {24'h0, rd_word[7:0]}
                                   : data_array_rdata_in;

   assign data_array_addr_out = {rd_addr[15:2], 2'h0};

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         data_rd_busy_out <= 1'b0;
         rd_ticks         <= 4'h0;
         rd_addr          <= 16'h0;
         rd_byte          <= 1'b0;
         rd_bad           <= 1'b0;
      end else if (rd_start) begin
         data_rd_busy_out <= 1'b1;
         rd_ticks         <= 4'h0;
         rd_addr          <= data_rd_addr_in;
         rd_byte          <= data_rd_byte_in;
         rd_bad           <= data_busy_pe;
      end else if (rd_last) begin
         data_rd_busy_out <= 1'b0;
      end else if (data_rd_busy_out && flash_tick) begin
         rd_ticks <= rd_ticks + 4'h1; // R02
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         data_rd_valid_out <= 1'b0;
         data_rd_data_out  <= 32'h0;
      end else begin
         data_rd_valid_out <= rd_last;
         if (rd_last) begin
            data_rd_data_out <= rd_bad ? 32'h0 : rd_value;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky flags, set wins over clear.

   wire code_set = code_bad || (reject && !cmd.data_array); // R14 R16
   wire data_set = (rd_start && data_busy_pe)
                   || (reject && cmd.data_array); // R14 R16 R12

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         code_flag <= 1'b0;
         data_flag <= 1'b0;
         lock_flag <= 1'b0;
      end else begin
         code_flag <= code_set || (code_flag && !code_viol_clear_in); // R14
         data_flag <= data_set || (data_flag && !data_viol_clear_in); // R14
         lock_flag <= lock_set || (lock_flag && !cmd_lock_clear_in); // R15
      end
   end

   assign code_array_violation_flag_out = code_flag;
   assign data_array_violation_flag_out = data_flag;
   assign command_lock_flag_out         = lock_flag;
   assign command_lock_irq_out = lock_flag && command_lock_irq_enable_in; // R15

   ////////////////////////////////////////////////////////////////////////
   // Interrupt acceptance is never gated by a running sequence.

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         irq_accept_out <= 1'b0;
      end else begin
         irq_accept_out <= irq_req_in; // R11
      end
   end

endmodule

`default_nettype wire

// ### dv/fas_array_model.sv
// Behavioural model of the code and data arrays behind the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fas_array_model (
   input  wire logic [21:0] code_addr_in,
   input  wire logic [15:0] data_addr_in,
   output logic      [31:0] code_rdata_out,
   output logic      [31:0] data_rdata_out
);
   // Each word carries its own address, so a wrong fetch shows at once.
   assign code_rdata_out = {10'h2a5, code_addr_in};
   assign data_rdata_out = {data_addr_in, ~data_addr_in};
endmodule
`default_nettype wire

// ### dv/fas_sequencer_props.sv
// Port assertions of the flash access sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "fas_map.svh"
module fas_sequencer_props
   import fas_pkg::*;
#(
   parameter logic [3:0] FLASH_CLOCK_DIV = 4'h2,
   parameter logic [7:0] PE_TICKS = 8'h10
) (
   input wire logic         clk_in,
   input wire logic         reset_in,
   input wire logic         code_rd_req_in,
   input wire logic [21:0]  code_rd_addr_in,
   input wire logic [31:0]  code_array_rdata_in,
   input wire logic         code_rd_valid_out,
   input wire logic [31:0]  code_rd_data_out,
   input wire logic         data_rd_req_in,
   input wire logic         data_rd_busy_out,
   input wire logic         data_rd_valid_out,
   input wire logic         cmd_wr_in,
   input wire logic [31:0]  cmd_addr_in,
   input wire logic [31:0]  cmd_data_in,
   input wire logic         code_array_pe_entry_in,
   input wire logic         data_array_pe_entry_in,
   input wire logic         serial_programmer_in,
   input wire logic         trusted_region_active_in,
   input wire logic         trusted_region_auth_in,
   input wire fas_arr_req_t arr_req_out,
   input wire logic         pe_busy_out,
   input wire logic         background_operation_out,
   input wire logic         code_array_violation_flag_out,
   input wire logic         data_array_violation_flag_out,
   input wire logic         command_lock_flag_out,
   input wire logic         command_lock_irq_enable_in,
   input wire logic         command_lock_irq_out,
   input wire logic         irq_req_in,
   input wire logic         irq_accept_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire logic hit = cmd_wr_in && cmd_addr_in == `FAS_CMD_BASE && !pe_busy_out;
   wire logic go = hit && !command_lock_flag_out;
   wire logic [7:0] opc = cmd_data_in[31:24];
   sequence s_taken;
      data_rd_req_in && !data_rd_busy_out;
   endsequence
   sequence s_wait;
      (!data_rd_valid_out)[*8] ##[8:9] data_rd_valid_out;
   endsequence
   AST_CODE_LAT: assert property (code_rd_req_in |=> code_rd_valid_out)
      else $error("code read answer late");
   AST_CODE_DATA: assert property (code_rd_req_in
      && !trusted_region_active_in
      && (!pe_busy_out || background_operation_out)
      |=> code_rd_data_out == $past(code_array_rdata_in))
      else $error("code read data wrong");
   AST_TM_BLOCK: assert property (code_rd_req_in && trusted_region_active_in
      && !trusted_region_auth_in && code_rd_addr_in[21:14] == 8'h04
      |=> code_rd_data_out == 32'h0 && code_array_violation_flag_out)
      else $error("trusted read not blocked");
   AST_DATA_LAT: assert property (s_taken |=> s_wait)
      else $error("data read latency wrong");
   AST_ERASE_CODE: assert property (go && code_array_pe_entry_in
      && cmd_data_in[31:22] == {`FAS_OP_ERASE, 2'h0} && cmd_data_in[12:0] == 13'h0
      |=> arr_req_out.op == FAS_ARR_ERASE && arr_req_out.fill == 8'hff
      && arr_req_out.len == `FAS_CODE_BLK_BYTES)
      else $error("code block erase wrong");
   AST_ERASE_DATA: assert property (go && data_array_pe_entry_in
      && !serial_programmer_in && cmd_data_in[31:22] == {`FAS_OP_ERASE, 2'h1}
      && cmd_data_in[21:16] == 6'h0 && cmd_data_in[5:0] == 6'h0
      |=> arr_req_out.op == FAS_ARR_ERASE && arr_req_out.len == 23'h40)
      else $error("data erase wrong");
   AST_NO_ENTRY: assert property (hit && !cmd_data_in[22]
      && !code_array_pe_entry_in && !data_array_pe_entry_in
      |=> arr_req_out.op == FAS_ARR_NONE && code_array_violation_flag_out)
      else $error("command without entry not refused");
   AST_SERIAL: assert property (hit && cmd_data_in[22] && serial_programmer_in
      |=> arr_req_out.op == FAS_ARR_NONE && data_array_violation_flag_out)
      else $error("data command on programmer path not refused");
   AST_BAD_OP: assert property (go && code_array_pe_entry_in
      && !cmd_data_in[22] && opc != 8'he8 && opc != 8'h20
      |=> command_lock_flag_out)
      else $error("bad opcode did not lock");
   AST_LOCK_IRQ: assert property (command_lock_irq_out
      == (command_lock_flag_out && command_lock_irq_enable_in))
      else $error("lock interrupt wrong");
   AST_IRQ: assert property (pe_busy_out && irq_req_in |=> irq_accept_out)
      else $error("interrupt refused while programming");
   AST_WIN_MISS: assert property (cmd_wr_in && cmd_addr_in != `FAS_CMD_BASE
      && !pe_busy_out |=> arr_req_out.op == FAS_ARR_NONE)
      else $error("write outside window ran a command");
endmodule
bind fas_sequencer fas_sequencer_props #(.FLASH_CLOCK_DIV(FLASH_CLOCK_DIV),
   .PE_TICKS(PE_TICKS)) fas_sequencer_props_i (.*);
`default_nettype wire

// ### dv/fas_sequencer_tb.sv
// Self-checking bench of the flash access sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "fas_map.svh"
module fas_sequencer_tb;
   import fas_pkg::*;
   logic clk_in = 1'h0;
   logic reset_in = 1'h1;
   logic code_rd_req_in, data_rd_req_in, data_rd_byte_in, cmd_wr_in;
   logic code_array_pe_entry_in, data_array_pe_entry_in, serial_programmer_in;
   logic trusted_region_active_in, trusted_region_auth_in, irq_req_in;
   logic code_viol_clear_in, data_viol_clear_in, cmd_lock_clear_in;
   logic command_lock_irq_enable_in, code_rd_valid_out, irq_accept_out;
   logic data_rd_busy_out, data_rd_valid_out, pe_busy_out;
   logic background_operation_out, command_lock_flag_out, command_lock_irq_out;
   logic code_array_violation_flag_out, data_array_violation_flag_out;
   logic [21:0] code_rd_addr_in, code_array_addr_out;
   logic [15:0] data_rd_addr_in, data_array_addr_out;
   logic [31:0] cmd_addr_in, cmd_data_in, code_array_rdata_in, r, w;
   logic [31:0] data_array_rdata_in, code_rd_data_out, data_rd_data_out;
   logic [31:0] seed = 32'hd2b39460;
   logic [31:0] cq[$], dq[$];
   fas_arr_req_t arr_req_out, e;
   fas_arr_req_t aq[$];
   int n_mismatch = 0;
   int num_checks = 0;
   fas_sequencer #(.PE_TICKS(8'h04)) fas_sequencer_i (.*);
   fas_array_model fas_array_model_i (.code_addr_in(code_array_addr_out),
      .data_addr_in(data_array_addr_out), .code_rdata_out(code_array_rdata_in),
      .data_rdata_out(data_array_rdata_in));
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic code_rd(input logic [21:0] a, input logic blk);
      code_rd_req_in = 1'h1;
      code_rd_addr_in = a;
      cq.push_back(blk ? 32'h0 : {10'h2a5, a});
      @(negedge clk_in);
   endtask
   task automatic data_rd(input logic [15:0] a, input logic b, input logic z);
      w = {a & 16'hfffc, ~(a & 16'hfffc)};
      dq.push_back(z ? 32'h0 : b ? {24'h0, w[8 * a[1:0] +: 8]} : w);
      {data_rd_req_in, data_rd_addr_in, data_rd_byte_in} = {1'h1, a, b};
      @(negedge clk_in);
      data_rd_req_in = 1'h0;
      @(negedge clk_in);
      {data_rd_req_in, data_rd_addr_in} = {1'h1, ~a};
      @(negedge clk_in);
      data_rd_req_in = 1'h0;
      repeat (30) if (data_rd_busy_out) @(negedge clk_in);
   endtask
   task automatic cmd(input logic [31:0] a, input logic [31:0] d);
      {cmd_wr_in, cmd_addr_in, cmd_data_in} = {1'h1, a, d};
      @(negedge clk_in);
      cmd_wr_in = 1'h0;
      @(negedge clk_in);
   endtask
   task automatic idle();
      repeat (60) if (pe_busy_out) @(negedge clk_in);
   endtask
   task automatic clear_all();
      {code_viol_clear_in, data_viol_clear_in, cmd_lock_clear_in} = 3'h7;
      @(negedge clk_in);
      {code_viol_clear_in, data_viol_clear_in, cmd_lock_clear_in} = 3'h0;
      @(negedge clk_in);
      check_flag(code_array_violation_flag_out | data_array_violation_flag_out
         | command_lock_flag_out, 1'h0);
   endtask
   // Results are matched against the oldest expectation of their kind.
   always @(negedge clk_in) begin
      if (code_rd_valid_out) begin
         r = ~code_rd_data_out;
         if (cq.size() != 0) r = cq.pop_front();
         check_word(code_rd_data_out, r);
      end
      if (data_rd_valid_out) begin
         r = ~data_rd_data_out;
         if (dq.size() != 0) r = dq.pop_front();
         check_word(data_rd_data_out, r);
      end
      if (arr_req_out.op != FAS_ARR_NONE) begin
         e = ~arr_req_out;
         if (aq.size() != 0) e = aq.pop_front();
         check_word(32'(arr_req_out.op), 32'(e.op));
         check_word(32'(arr_req_out.addr), 32'(e.addr));
         check_word(32'(arr_req_out.len), 32'(e.len));
         if (e.op != FAS_ARR_ERASE)
            check_word(arr_req_out.wdata, e.wdata);
         if (e.op == FAS_ARR_ERASE && !e.data_array)
            check_word(32'(arr_req_out.fill), 32'h0ff);
      end
   end
   initial begin
      {code_rd_req_in, code_rd_addr_in, data_rd_req_in, data_rd_byte_in,
       data_rd_addr_in, cmd_wr_in, cmd_addr_in, cmd_data_in, irq_req_in,
       code_array_pe_entry_in, data_array_pe_entry_in, serial_programmer_in,
       trusted_region_active_in, trusted_region_auth_in, code_viol_clear_in,
       data_viol_clear_in, cmd_lock_clear_in, command_lock_irq_enable_in} = '0;
      repeat (12) @(negedge clk_in);
      reset_in = 1'h0;
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         code_rd({r[21:2], 2'h0}, 1'h0);
      end
      trusted_region_active_in = 1'h1;
      code_rd(22'h010000, 1'h1);
      code_rd(22'h013ffc, 1'h1);
      code_rd(22'h014000, 1'h0);
      trusted_region_auth_in = 1'h1;
      code_rd(22'h013ffc, 1'h0);
      {code_rd_req_in, trusted_region_active_in} = 2'h0;
      @(negedge clk_in);
      check_flag(code_array_violation_flag_out, 1'h1);
      clear_all();
      cmd(`FAS_CMD_BASE, 32'h2000_2000);
      check_flag(code_array_violation_flag_out, 1'h1);
      clear_all();
      code_array_pe_entry_in = 1'h1;
      cmd(`FAS_CMD_BASE + 32'h4, 32'h2000_2000);
      aq.push_back('{FAS_ARR_ERASE, 1'h0, 1'h0, 22'h2000, 23'h2000, 32'h0, 8'hff});
      cmd(`FAS_CMD_BASE, 32'h2000_2000);
      irq_req_in = 1'h1;
      code_rd(22'h200100, 1'h0);
      code_rd(22'h000100, 1'h1);
      code_rd_req_in = 1'h0;
      check_flag(irq_accept_out, 1'h1);
      irq_req_in = 1'h0;
      idle();
      check_flag(code_array_violation_flag_out, 1'h1);
      clear_all();
      aq.push_back('{FAS_ARR_ERASE, 1'h0, 1'h1, 22'h0, 23'h8000, 32'h0, 8'hff});
      cmd(`FAS_CMD_BASE, 32'h2080_0000);
      check_flag(pe_busy_out, 1'h1);
      idle();
      check_flag(pe_busy_out, 1'h0);
      command_lock_irq_enable_in = 1'h1;
      cmd(`FAS_CMD_BASE, 32'h5500_0000);
      check_flag(command_lock_irq_out, 1'h1);
      cmd(`FAS_CMD_BASE, 32'h2000_4000);
      clear_all();
      check_flag(command_lock_irq_out, 1'h0);
      cmd(`FAS_CMD_BASE, 32'he800_4000);
      for (int i = 0; i < 64; i++) begin
         aq.push_back('{i < 63 ? FAS_ARR_WRITE : FAS_ARR_COMMIT, 1'h0, 1'h0,
            22'h4000 + 22'(4 * i), 23'h100, 32'(i), 8'h0});
         cmd(`FAS_CMD_BASE, 32'(i));
      end
      idle();
      {code_array_pe_entry_in, data_array_pe_entry_in} = 2'h1;
      serial_programmer_in = 1'h1;
      cmd(`FAS_CMD_BASE, 32'h2040_0040);
      check_flag(data_array_violation_flag_out, 1'h1);
      serial_programmer_in = 1'h0;
      clear_all();
      aq.push_back('{FAS_ARR_ERASE, 1'h1, 1'h0, 22'h40, 23'h40, 32'h0, 8'h0});
      cmd(`FAS_CMD_BASE, 32'h2040_0040);
      check_flag(background_operation_out, 1'h1);
      code_rd(22'h000200, 1'h0);
      code_rd_req_in = 1'h0;
      data_rd(16'h0044, 1'h0, 1'h1);
      check_flag(data_array_violation_flag_out, 1'h1);
      idle();
      w = rnd();
      aq.push_back('{FAS_ARR_COMMIT, 1'h1, 1'h0, 22'h10, 23'h4, w, 8'h0});
      cmd(`FAS_CMD_BASE, 32'he840_0010);
      cmd(`FAS_CMD_BASE, w);
      idle();
      data_array_pe_entry_in = 1'h0;
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         data_rd(r[16] ? r[15:0] : {r[15:2], 2'h0}, r[16], 1'h0);
      end
      repeat (4) @(negedge clk_in);
      check_word(32'(cq.size() + dq.size() + aq.size()), 32'h0);
      final_report();
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #(8 * 3000);
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
